// ### core/sre_top.sv
// Read engine of a two-wire serial EEPROM slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module sre_top #(
    parameter logic [3:0] TYPE_CODE = sre_pkg::TYPE_CODE_DEF // Arbitrary value
) (
    input  wire logic                       i_clock,
    input  wire logic                       i_rst,
    input  wire logic                       i_scl,
    input  wire logic                       i_sda,
    output logic                            o_sda,
    output logic                            o_sda_oe,
    input  wire logic                       i_prog_busy,
    input  wire logic                       i_wr_en,
    input  wire logic [sre_pkg::ADDR_W-1:0] i_wr_addr,
    input  wire logic [sre_pkg::DATA_W-1:0] i_wr_data,
    output logic      [sre_pkg::ADDR_W-1:0] o_addr,
    output logic                            o_active
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sre_pkg::sre_pins_s meta_r, sync_r, prev_r;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= 2'h3;
            sync_r <= 2'h3;
            prev_r <= 2'h3;
        end else begin
            meta_r <= '{scl: i_scl, sda: i_sda};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    wire scl_rise = sync_r.scl & ~prev_r.scl;
    wire scl_fall = ~sync_r.scl & prev_r.scl;
    wire start_ev = prev_r.scl & sync_r.scl & prev_r.sda & ~sync_r.sda;
    wire stop_ev  = prev_r.scl & sync_r.scl & ~prev_r.sda & sync_r.sda;

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    sre_pkg::sre_state_e state_r, state_nxt;
    logic [sre_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [sre_pkg::DATA_W-1:0] shift_r, shift_nxt;
    logic [3:0]                 bit_r, bit_nxt;
    logic                       drive_low_r, drive_low_nxt;
    logic                       rd_dir_r, rd_dir_nxt;
    logic [sre_pkg::HI_W-1:0]   hi_r, hi_nxt;
    logic [sre_pkg::ADDR_W-1:0] fetch_addr_r;

    // Two-entry buffer of prefetched bytes between memory and shifter
    sre_pkg::sre_word_s         buf_r [2];
    logic [1:0]                 buf_cnt_r;
    logic [sre_pkg::DATA_W-1:0] mem_q;
    logic                       mem_vld_r;

    wire [7:0] rx_byte  = {shift_r[6:0], sync_r.sda};
    wire       sel_hit  = rx_byte[7 -: sre_pkg::TYPE_W] == TYPE_CODE;
    wire       sel_ok   = sel_hit & ~i_prog_busy;
    wire       buf_in_rdy  = (buf_cnt_r != sre_pkg::BUF_DEPTH);
    wire       buf_out_vld = (buf_cnt_r != 2'h0);
    wire       take_word;
    wire       flush = start_ev | stop_ev;
    wire       byte_done = (bit_r == sre_pkg::BIT_LAST);
    wire [sre_pkg::ADDR_W-1:0] fetch_addr = addr_r + {9'h000, buf_cnt_r}
                                            + {10'h000, mem_vld_r};
    wire       fetch_go = buf_in_rdy & ~mem_vld_r & ~flush
                          & ((buf_cnt_r + {1'b0, mem_vld_r}) < sre_pkg::BUF_DEPTH)
                          & (state_r inside {sre_pkg::SRE_SEND, sre_pkg::SRE_MACK,
                                             sre_pkg::SRE_SEL_ACK});

    always_comb begin
        state_nxt     = state_r;
        addr_nxt      = addr_r;
        shift_nxt     = shift_r;
        bit_nxt       = bit_r;
        drive_low_nxt = drive_low_r;
        rd_dir_nxt    = rd_dir_r;
        hi_nxt        = hi_r;
        if (start_ev) begin
            state_nxt     = sre_pkg::SRE_SELECT;
            bit_nxt       = sre_pkg::BIT_ZERO;
            drive_low_nxt = 1'b0;
        end else if (stop_ev) begin
            state_nxt     = sre_pkg::SRE_IDLE;
            drive_low_nxt = 1'b0;
        end else begin
            unique case (state_r)
                sre_pkg::SRE_IDLE: begin
                end
                sre_pkg::SRE_SELECT, sre_pkg::SRE_ADDR: begin
                    if (scl_rise) begin
                        shift_nxt = rx_byte;
                        bit_nxt   = bit_r + 4'h1;
                        if (byte_done && state_r == sre_pkg::SRE_SELECT) begin
                            if (sel_ok) begin
                                state_nxt  = sre_pkg::SRE_SEL_ACK;
                                rd_dir_nxt = rx_byte[sre_pkg::SEL_DIR_BIT];
                                hi_nxt     = rx_byte[sre_pkg::SEL_HI_LSB +: sre_pkg::HI_W];
                                // Upper bits come from the select byte even on a read; set here
                                // so the prefetch already fetches from the right page
                                if (rx_byte[sre_pkg::SEL_DIR_BIT]) begin
                                    addr_nxt = {rx_byte[sre_pkg::SEL_HI_LSB +: sre_pkg::HI_W],
                                                addr_r[sre_pkg::LO_W-1:0]};
                                end
                            end else begin
                                state_nxt = sre_pkg::SRE_IDLE;
                            end
                        end else if (byte_done) begin
                            state_nxt = sre_pkg::SRE_ADDR_ACK;
                            addr_nxt  = {hi_r, rx_byte};
                        end
                    end
                    if (scl_fall && bit_r == 4'h8) begin
                        drive_low_nxt = 1'b1;
                    end
                end
                sre_pkg::SRE_SEL_ACK, sre_pkg::SRE_ADDR_ACK: begin
                    if (scl_fall && drive_low_r) begin
                        bit_nxt = sre_pkg::BIT_ZERO;
                        if (state_r == sre_pkg::SRE_ADDR_ACK) begin
                            drive_low_nxt = 1'b0;
                            state_nxt     = sre_pkg::SRE_IDLE;
                        end else if (rd_dir_r) begin
                            // First data bit leaves on the same fall that ends the acknowledge
                            state_nxt     = sre_pkg::SRE_SEND;
                            drive_low_nxt = ~buf_r[0].data[sre_pkg::DATA_W-1];
                            bit_nxt       = 4'h1;
                        end else begin
                            drive_low_nxt = 1'b0;
                            state_nxt     = sre_pkg::SRE_ADDR;
                        end
                    end else if (scl_fall) begin
                        drive_low_nxt = 1'b1;
                    end
                end
                sre_pkg::SRE_SEND: begin
                    // Release after the eighth bit so the master can acknowledge
                    if (scl_fall && bit_r == 4'h8) begin
                        drive_low_nxt = 1'b0;
                        state_nxt     = sre_pkg::SRE_MACK;
                        addr_nxt      = addr_r + sre_pkg::ADDR_ONE;
                    end else if (scl_fall) begin
                        drive_low_nxt = ~buf_r[0].data[3'(sre_pkg::BIT_LAST - bit_r)];
                        bit_nxt       = bit_r + 4'h1;
                    end
                end
                sre_pkg::SRE_MACK: begin
                    if (scl_rise) begin
                        bit_nxt   = sre_pkg::BIT_ZERO;
                        // Low acknowledge continues; high ends until stop
                        state_nxt = sync_r.sda ? sre_pkg::SRE_IDLE : sre_pkg::SRE_SEND;
                    end
                end
                default: state_nxt = sre_pkg::SRE_IDLE;
            endcase
        end
    end
    // Byte leaves the buffer once its last bit has gone out
    assign take_word = (state_r == sre_pkg::SRE_MACK) & scl_rise;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_r     <= sre_pkg::SRE_IDLE;
            addr_r      <= sre_pkg::ADDR_RST;
            shift_r     <= 8'h00;
            bit_r       <= 4'h0;
            drive_low_r <= 1'b0;
            rd_dir_r    <= 1'b0;
            hi_r        <= 3'h0;
        end else begin
            state_r     <= state_nxt;
            addr_r      <= addr_nxt;
            shift_r     <= shift_nxt;
            bit_r       <= bit_nxt;
            drive_low_r <= drive_low_nxt;
            rd_dir_r    <= rd_dir_nxt;
            hi_r        <= hi_nxt;
        end
    end

    // ------------------------------------------------------------
    // Prefetch buffer
    // ------------------------------------------------------------
    // Prefetch hides memory latency; flushed on any start or stop
    // so a reloaded counter never serves stale bytes.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            buf_cnt_r    <= 2'h0;
            mem_vld_r    <= 1'b0;
            fetch_addr_r <= sre_pkg::ADDR_RST;
            buf_r[0]     <= '0;
            buf_r[1]     <= '0;
        end else if (flush || state_r == sre_pkg::SRE_IDLE) begin
            buf_cnt_r <= 2'h0;
            mem_vld_r <= 1'b0;
        end else begin
            mem_vld_r <= fetch_go;
            // Label kept with the read so it matches the data one cycle later
            if (fetch_go) begin
                fetch_addr_r <= fetch_addr;
            end
            if (take_word) begin
                buf_r[0] <= buf_r[1];
            end
            if (mem_vld_r && buf_in_rdy) begin
                if (take_word || buf_cnt_r == 2'h0) begin
                    buf_r[buf_cnt_r == 2'h2 ? 1 : 0] <= '{addr: fetch_addr_r, data: mem_q};
                end
                if (!take_word && buf_cnt_r == 2'h1) begin
                    buf_r[1] <= '{addr: fetch_addr_r, data: mem_q};
                end
                if (take_word && buf_cnt_r == 2'h1) begin
                    buf_r[0] <= '{addr: fetch_addr_r, data: mem_q};
                end
            end
            buf_cnt_r <= buf_cnt_r + {1'b0, mem_vld_r & buf_in_rdy}
                         - {1'b0, take_word & buf_out_vld};
        end
    end

    sre_mem u_mem (
        .i_clock   (i_clock),
        .i_rd_en   (fetch_go),
        .i_rd_addr (fetch_addr),
        .o_rd_data (mem_q),
        .i_wr_en   (i_wr_en),
        .i_wr_addr (i_wr_addr),
        .i_wr_data (i_wr_data)
    );

    assign o_sda    = 1'b0;
    assign o_sda_oe = drive_low_r;
    assign o_addr   = addr_r;
    assign o_active = (state_r != sre_pkg::SRE_IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_busy_no_ack: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_r == sre_pkg::SRE_SELECT && scl_rise && byte_done && i_prog_busy)
        |=> state_r != sre_pkg::SRE_SEL_ACK)
        else $error("Select acknowledged while busy");
    a_sda_on_fall: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_r == sre_pkg::SRE_SEND && $changed(drive_low_r)) |-> $past(scl_fall))
        else $error("Data changed away from a falling edge");
    a_addr_step: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_r == sre_pkg::SRE_SEND && state_nxt == sre_pkg::SRE_MACK)
        |=> addr_r == $past(addr_r) + sre_pkg::ADDR_ONE)
        else $error("Counter did not step by one");
    a_addr_wrap: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_nxt == sre_pkg::SRE_MACK && state_r == sre_pkg::SRE_SEND
         && addr_r == 11'h7ff) |=> addr_r == 11'h000)
        else $error("Counter did not wrap");
    a_addr_load: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_r == sre_pkg::SRE_ADDR && scl_rise && byte_done)
        |=> addr_r[7:0] == $past(rx_byte))
        else $error("Address byte not loaded");
    a_mack_end: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_r == sre_pkg::SRE_MACK && scl_rise && !sync_r.sda && !start_ev && !stop_ev)
        |=> state_r == sre_pkg::SRE_SEND)
        else $error("Acknowledge did not continue the read");
    a_stop_idle: assert property (@(posedge i_clock) disable iff (i_rst)
        stop_ev |=> (state_r == sre_pkg::SRE_IDLE && !o_sda_oe))
        else $error("Stop did not release the bus");
    a_read_hi: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_r == sre_pkg::SRE_SEL_ACK && state_nxt == sre_pkg::SRE_SEND)
        |=> addr_r[10:8] == $past(hi_r))
        else $error("Select bits not used as high address");
    a_buf_word_addr: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_r == sre_pkg::SRE_SEND && buf_out_vld) |-> buf_r[0].addr == addr_r)
        else $error("Buffered byte is not from the counter location");
endmodule
`default_nettype wire

// ### core/sre_pkg.sv
// Shared constants and carrier types for the serial EEPROM read engine
package sre_pkg;
    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W    = 11;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned MEM_DEPTH = 2048;
    localparam int unsigned HI_W      = 3;
    localparam int unsigned LO_W      = 8;
    // ------------------------------------------------------------
    // Select byte layout
    // ------------------------------------------------------------
    localparam int unsigned SEL_DIR_BIT = 0;
    localparam int unsigned SEL_HI_LSB  = 1;
    localparam int unsigned SEL_TYPE_LSB = 4;
    localparam int unsigned TYPE_W      = 4;
    // Type code value is arbitrary here
    localparam logic [3:0]  TYPE_CODE_DEF = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
    localparam logic [3:0]  BIT_LAST  = 4'h7;
    localparam logic [3:0]  BIT_ZERO  = 4'h0;
    localparam logic [1:0]  BUF_DEPTH = 2'h2;

    // ------------------------------------------------------------
    // Bus states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRE_IDLE     = 3'b000,
        SRE_SELECT   = 3'b001,
        SRE_SEL_ACK  = 3'b011,
        SRE_ADDR     = 3'b010,
        SRE_ADDR_ACK = 3'b110,
        SRE_SEND     = 3'b111,
        SRE_MACK     = 3'b101
    } sre_state_e;

    typedef struct packed {
        logic       scl;
        logic       sda;
    } sre_pins_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sre_word_s;
endpackage

// ### core/sre_mem.sv
// Byte memory with registered read data and a write port
`timescale 1ns/1ns
`default_nettype none
module sre_mem (
    input  wire logic                      i_clock,
    input  wire logic                      i_rd_en,
    input  wire logic [sre_pkg::ADDR_W-1:0] i_rd_addr,
    output logic      [sre_pkg::DATA_W-1:0] o_rd_data,
    input  wire logic                      i_wr_en,
    input  wire logic [sre_pkg::ADDR_W-1:0] i_wr_addr,
    input  wire logic [sre_pkg::DATA_W-1:0] i_wr_data
);
    logic [sre_pkg::DATA_W-1:0] mem_r [sre_pkg::MEM_DEPTH];

    // No reset on the array so it maps to block memory
    always_ff @(posedge i_clock) begin
        if (i_wr_en) begin
            mem_r[i_wr_addr] <= i_wr_data;
        end
        if (i_rd_en) begin
            o_rd_data <= mem_r[i_rd_addr];
        end
    end
endmodule
`default_nettype wire

// ### bench/sre_master.sv
// Two-wire bus master model that drives the bus clock and the master side of the data line
`timescale 1ns/1ns
`default_nettype none
module sre_master (
    input  wire logic i_clock,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    // ------------------------------------------------------------
    // Bus phases, one quarter of a 160 ns bus clock each
    // ------------------------------------------------------------
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    task automatic q();
        repeat (4) @(posedge i_clock);
    endtask

    // Data is set while the clock is low and sampled mid-high, so no false start or stop
    task automatic bit_io(input logic v, output logic s);
        o_sda_oe <= ~v;
        q();
        o_scl <= 1'b1;
        q();
        s = i_sda;
        q();
        o_scl <= 1'b0;
        q();
    endtask

    // Also serves as repeated start between the address load and the read
    task automatic bus_start();
        o_sda_oe <= 1'b0;
        q();
        o_scl <= 1'b1;
        q();
        o_sda_oe <= 1'b1;
        q();
        o_scl <= 1'b0;
        q();
    endtask

    // Closes a read after the final no-acknowledge; clock then stands high
    task automatic bus_stop();
        o_sda_oe <= 1'b1;
        q();
        o_scl <= 1'b1;
        q();
        o_sda_oe <= 1'b0;
        q();
    endtask

    // Select and address bytes go out MSB first; ninth bit is left to the device
    task automatic put_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, ack_n);
    endtask

    // Acknowledge low asks for one more byte, high ends the read
    task automatic get_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(~more, s);
    endtask
endmodule
`default_nettype wire

// ### bench/sre_top_tb.sv
// Self-checking bench for the serial EEPROM read engine
`timescale 1ns/1ns
`default_nettype none
module sre_top_tb;
    // Type code value is arbitrary
    localparam logic [3:0] TC = 4'h6;
    logic        i_clock     = 1'b0;
    logic        i_rst       = 1'b1;
    logic        i_prog_busy = 1'b0;
    logic        i_wr_en     = 1'b0;
    logic [10:0] i_wr_addr   = 11'h000;
    logic [7:0]  i_wr_data   = 8'h00;
    logic        scl;
    logic        m_oe;
    logic        o_sda;
    logic        o_sda_oe;
    logic [10:0] o_addr;
    logic        o_active;
    logic        oe_q        = 1'b0;
    logic        scl_q       = 1'b1;
    wire logic   sda_line;
    int          failures    = 0;
    int          checked     = 0;

    // ------------------------------------------------------------
    // Clock, wired-and data line with pull-up, parties
    // ------------------------------------------------------------
    always #5 i_clock = ~i_clock;
    assign sda_line = ~(m_oe | (o_sda_oe & ~o_sda));

    sre_top #(.TYPE_CODE(TC)) dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line),
        .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_prog_busy(i_prog_busy),
        .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
        .o_addr(o_addr), .o_active(o_active)
    );
    sre_master m (.i_clock(i_clock), .i_sda(sda_line), .o_scl(scl), .o_sda_oe(m_oe));

    // Sampled on the falling system edge so the registered enable has settled
    always @(negedge i_clock) begin
        oe_q  <= o_sda_oe;
        scl_q <= scl;
        if (!i_rst && scl && scl_q && o_sda_oe !== oe_q) begin
            failures++;
            $display("[ERR] data change in clock high expected %h seen %h", oe_q, o_sda_oe);
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] pat(input logic [10:0] a);
        return a[7:0] ^ {a[10:8], a[10:8], 2'b01};
    endfunction

    task automatic check(input string name, input logic [10:0] exp, input logic [10:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic fill();
        for (int a = 0; a < sre_pkg::MEM_DEPTH; a++) begin
            @(posedge i_clock);
            i_wr_en   <= 1'b1;
            i_wr_addr <= 11'(a);
            i_wr_data <= pat(11'(a));
        end
        @(posedge i_clock);
        i_wr_en <= 1'b0;
    endtask

    task automatic load(input logic [10:0] a);
        logic ack_n;
        m.bus_start();
        m.put_byte({TC, a[10:8], 1'b0}, ack_n);
        check("select write ack", 11'h000, 11'(ack_n));
        m.put_byte(a[7:0], ack_n);
        check("address ack", 11'h000, 11'(ack_n));
    endtask

    task automatic read_n(input logic [2:0] hi, input logic [10:0] a, input int n);
        logic        ack_n;
        logic [7:0]  b;
        logic [10:0] e;
        e = a;
        m.bus_start();
        m.put_byte({TC, hi, 1'b1}, ack_n);
        check("select read ack", 11'h000, 11'(ack_n));
        for (int k = 0; k < n; k++) begin
            m.get_byte(k < n - 1, b);
            check("read data", 11'(pat(e)), 11'(b));
            e = e + 11'h001;
        end
        m.bus_stop();
        check("counter after read", e, o_addr);
        repeat (8) @(posedge i_clock);
        check("idle after stop", 11'h000, 11'(o_active));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("reset counter", 11'h000, o_addr);
        check("reset enable", 11'h000, 11'(o_sda_oe));
        check("drive value", 11'h000, 11'(o_sda));
        check("reset active", 11'h000, 11'(o_active));
    endtask

    task automatic t_random();
        load(11'h123);
        read_n(3'h1, 11'h123, 1);
    endtask

    task automatic t_current();
        read_n(3'h1, 11'h124, 2);
    endtask

    task automatic t_wrap();
        load(11'h7fe);
        read_n(3'h7, 11'h7fe, 3);
    endtask

    // Busy device and a foreign type code both leave the select unanswered
    task automatic t_refuse();
        logic ack_n;
        for (int c = 0; c < 2; c++) begin
            i_prog_busy <= (c == 0);
            m.bus_start();
            m.put_byte({(c == 0) ? TC : ~TC, 3'h7, 1'b1}, ack_n);
            check("refused select ack", 11'h001, 11'(ack_n));
            m.bus_stop();
            check("counter kept", 11'h001, o_addr);
            i_prog_busy <= 1'b0;
        end
    endtask

    // Run is near 4400 cycles; the limit allows about seven times that
    initial begin
        #300000;
        failures++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge i_clock);
        t_reset();
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clock);
        fill();
        repeat (4) @(posedge i_clock);
        t_random();
        t_current();
        t_wrap();
        t_refuse();
        finish_test();
    end
endmodule
`default_nettype wire
